// File: src/host_pin_logic.sv
// Host bus decode, modem pins and interrupt pins of a dual serial
// controller with printer port. Assumes synchronous host strobes.
`timescale 1ns/1ps
// Overview of operation
// - Modem status bit 5 shows the channel's data-set-ready input level.
// - Modem status bit 1 flags a data-set-ready change since the last read.
// - Terminal-ready pin is low while modem control bit 0 is set.
// - Any reset returns each terminal-ready pin high.
// - Source select low: parallel interrupt follows the acknowledge input.
// - Source select high: parallel interrupt follows the status interrupt flag.
// - Source select high: parallel interrupt latches high on each acknowledge rising edge.
// - Clearing the init control bit pulls the init line low, open drain.
// - Read strobe low drives the selected register onto the data bus.
// - Select 0 and 1 address the serial channels, select 2 the printer.
// - Write strobe low loads the bus into the selected register.
// - Serial interrupt pin driven only while modem control bit 3 is set.
// - Serial interrupt rises when any enabled source is active.
// - Serial interrupt drops after the matching service action.
// - After reset both serial interrupt pins float.
// - Printer control bit 4 enables the parallel interrupt pin.
// - After reset the parallel interrupt pin floats.
// - Reset clears modem control: serial interrupt pins float, terminal-ready pins go high.
module host_pin_logic
  import host_pin_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [2:0] register_select_lines_in,
  input wire logic select_serial_a_n_in,
  input wire logic select_serial_b_n_in,
  input wire logic select_lineport_n_in,
  input wire logic host_read_strobe_n_in,
  input wire logic host_write_strobe_n_in,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  input wire logic [1:0] set_ready_in,
  output logic [1:0] terminal_ready_out,
  input wire logic [1:0] rx_avail_in,
  input wire logic [1:0] line_error_in,
  input wire logic [1:0] tx_empty_in,
  input wire logic [15:0] rx_data_in,
  output logic [1:0] rx_read_out,
  output logic [1:0] line_status_read_out,
  output logic [1:0] tx_write_out,
  output logic [1:0] serial_irq_out,
  output logic [1:0] serial_irq_oe_out,
  input wire logic printer_ack_in,
  input wire logic printer_busy_in,
  input wire logic paper_empty_in,
  input wire logic printer_select_in,
  input wire logic printer_error_n_in,
  input wire logic parallel_irq_source_sel_in,
  output logic parallel_irq_out,
  output logic parallel_irq_oe_out,
  input wire logic printer_init_in,
  output logic printer_init_out,
  output logic printer_init_oe_out
);
  logic [2:0] sel;
  logic rd_act, wr_act, rd_start, wr_start;
  logic rd_q, rd_d, wr_q, wr_d;
  logic [7:0] bus_q, bus_d;
  logic [7:0] ch_rdata [2];
  logic [7:0] par_rdata;
  logic [7:0] pdata_q, pdata_d, ctrl_q, ctrl_d;
  logic flag_q, flag_d, ack_q, ack_d, pirq_q, pirq_d;
  logic [7:0] status;

  // Host can only select one target at a time
  assign sel = {~select_lineport_n_in, ~select_serial_b_n_in, ~select_serial_a_n_in};
  assign rd_act = ~host_read_strobe_n_in && (|sel);
  assign wr_act = ~host_write_strobe_n_in && (|sel);
  // Side effects fire once per strobe, not per cycle held
  assign rd_start = rd_act && !rd_q;
  assign wr_start = wr_act && !wr_q;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      serial_channel_regs u_chan (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .addr_in(register_select_lines_in),
        .read_pulse_in(rd_start && sel[ch]),
        .write_pulse_in(wr_start && sel[ch]),
        .wdata_in(host_data_bus_in),
        .set_ready_in(set_ready_in[ch]),
        .rx_avail_in(rx_avail_in[ch]),
        .line_error_in(line_error_in[ch]),
        .tx_empty_in(tx_empty_in[ch]),
        .rx_data_in(rx_data_in[ch*8 +: 8]),
        .rdata_out(ch_rdata[ch]),
        .terminal_ready_out(terminal_ready_out[ch]),
        .irq_out(serial_irq_out[ch]),
        .irq_oe_out(serial_irq_oe_out[ch]),
        .rx_read_out(rx_read_out[ch]),
        .line_status_read_out(line_status_read_out[ch]),
        .tx_write_out(tx_write_out[ch])
      );
    end
  endgenerate

  // Error level passes straight through; the printer keeps it valid
  assign status = {~printer_busy_in, ack_q, paper_empty_in, printer_select_in,
                   printer_error_n_in, flag_q, 2'h0};

  always_comb begin
    case (register_select_lines_in)
      PAR_DATA_OFS: par_rdata = pdata_q;
      PAR_STAT_OFS: par_rdata = status;
      PAR_CTRL_OFS: par_rdata = {ctrl_q[7:3], printer_init_in, ctrl_q[1:0]};
      default: par_rdata = 8'hff;
    endcase
  end

  // Bus capture and strobe history
  always_comb begin
    rd_d = rd_act;
    wr_d = wr_act;
    bus_d = bus_q;
    // Freeze at the first low cycle so read side effects do not show
    if (rd_start) begin
      if (sel[0]) begin
        bus_d = ch_rdata[0];
      end else if (sel[1]) begin
        bus_d = ch_rdata[1];
      end else begin
        bus_d = par_rdata;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      bus_q <= REG_RESET;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      bus_q <= bus_d;
    end
  end

  assign host_data_bus_out = bus_q;
  assign host_data_bus_oe_out = rd_act;

  // Parallel port registers and interrupt
  always_comb begin
    pdata_d = pdata_q;
    ctrl_d = ctrl_q;
    flag_d = flag_q;
    ack_d = printer_ack_in;
    if (wr_start && sel[2]) begin
      case (register_select_lines_in)
        PAR_DATA_OFS: pdata_d = host_data_bus_in;
        PAR_CTRL_OFS: ctrl_d = host_data_bus_in;
        default: ;
      endcase
    end
    if (rd_start && sel[2] && register_select_lines_in == PAR_STAT_OFS) begin
      flag_d = 1'b0;
    end
    // Edge beats a same-cycle status read
    if (printer_ack_in && !ack_q) begin
      flag_d = 1'b1;
    end
    if (parallel_irq_source_sel_in) begin
      pirq_d = flag_q;
    end else begin
      pirq_d = ack_q;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pdata_q <= REG_RESET;
      ctrl_q <= CTRL_RESET;
      flag_q <= 1'b0;
      ack_q <= 1'b0;
      pirq_q <= 1'b0;
    end else begin
      pdata_q <= pdata_d;
      ctrl_q <= ctrl_d;
      flag_q <= flag_d;
      ack_q <= ack_d;
      pirq_q <= pirq_d;
    end
  end

  assign parallel_irq_out = pirq_q;
  assign parallel_irq_oe_out = ctrl_q[CTRL_IRQ_EN_BIT];
  // Open drain: only ever pulls low
  assign printer_init_out = 1'b0;
  assign printer_init_oe_out = ~ctrl_q[CTRL_INIT_BIT];

  property p_dsr_level;
    @(posedge clock_in) disable iff (reset_in)
      (rd_start && sel[0] && register_select_lines_in == SER_MSR_OFS && $stable(set_ready_in[0]))
      |=> host_data_bus_out[MSR_DSR_BIT] == $past(set_ready_in[0]);
  endproperty
  a_dsr_level: assert property (p_dsr_level) else $error("dsr level not shown");
  property p_dsr_delta;
    @(posedge clock_in) disable iff (reset_in)
      ($changed(set_ready_in[0]) ##1 (rd_start && sel[0] && register_select_lines_in == SER_MSR_OFS))
      |=> host_data_bus_out[MSR_DDSR_BIT];
  endproperty
  a_dsr_delta: assert property (p_dsr_delta) else $error("dsr change not flagged");
  property p_dtr_write;
    @(posedge clock_in) disable iff (reset_in)
      (wr_start && sel[0] && register_select_lines_in == SER_MCR_OFS)
      |=> terminal_ready_out[0] == !$past(host_data_bus_in[MCR_DTR_BIT]);
  endproperty
  a_dtr_write: assert property (p_dtr_write) else $error("dtr wrong after write");
  property p_reset_outs;
    @(posedge clock_in) reset_in |=>
      (terminal_ready_out == 2'h3 && serial_irq_oe_out == 2'h0 && !parallel_irq_oe_out);
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("outputs wrong after reset");
  property p_src_ack;
    @(posedge clock_in) disable iff (reset_in)
      ($past(parallel_irq_source_sel_in) == 1'b0 && !$past(reset_in, 2))
      |-> parallel_irq_out == $past(printer_ack_in, 2);
  endproperty
  a_src_ack: assert property (p_src_ack) else $error("irq not from ack");
  property p_src_flag;
    @(posedge clock_in) disable iff (reset_in)
      $past(parallel_irq_source_sel_in) |-> parallel_irq_out == $past(flag_q);
  endproperty
  a_src_flag: assert property (p_src_flag) else $error("irq not from flag");
  property p_ack_rise;
    @(posedge clock_in) disable iff (reset_in) $rose(printer_ack_in) |-> ##2 parallel_irq_out;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack edge not latched");
  property p_init_drive;
    @(posedge clock_in) disable iff (reset_in)
      (wr_start && sel[2] && register_select_lines_in == PAR_CTRL_OFS && !host_data_bus_in[CTRL_INIT_BIT])
      |=> printer_init_oe_out && !printer_init_out;
  endproperty
  a_init_drive: assert property (p_init_drive) else $error("init not pulled low");
  property p_read_hold;
    @(posedge clock_in) disable iff (reset_in)
      (rd_act ##1 rd_act) |-> host_data_bus_oe_out ##1 (!rd_act || $stable(host_data_bus_out));
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data unstable");
  property p_irq_en;
    @(posedge clock_in) disable iff (reset_in)
      (wr_start && sel[1] && register_select_lines_in == SER_MCR_OFS)
      |=> serial_irq_oe_out[1] == $past(host_data_bus_in[MCR_IRQ_EN_BIT]);
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("serial irq enable wrong");
  property p_par_en;
    @(posedge clock_in) disable iff (reset_in)
      (wr_start && sel[2] && register_select_lines_in == PAR_CTRL_OFS)
      |=> parallel_irq_oe_out == $past(host_data_bus_in[CTRL_IRQ_EN_BIT]);
  endproperty
  a_par_en: assert property (p_par_en) else $error("parallel irq enable wrong");
  property p_bus_float;
    @(posedge clock_in) disable iff (reset_in) !rd_act |-> !host_data_bus_oe_out;
  endproperty
  a_bus_float: assert property (p_bus_float) else $error("bus driven without read");
  property p_dtr_write_b;
    @(posedge clock_in) disable iff (reset_in)
      (wr_start && sel[1] && register_select_lines_in == SER_MCR_OFS)
      |=> terminal_ready_out[1] == !$past(host_data_bus_in[MCR_DTR_BIT]);
  endproperty
  a_dtr_write_b: assert property (p_dtr_write_b) else $error("dtr b wrong after write");
  property p_irq_en_a;
    @(posedge clock_in) disable iff (reset_in)
      (wr_start && sel[0] && register_select_lines_in == SER_MCR_OFS)
      |=> serial_irq_oe_out[0] == $past(host_data_bus_in[MCR_IRQ_EN_BIT]);
  endproperty
  a_irq_en_a: assert property (p_irq_en_a) else $error("serial irq a enable wrong");
  // Held strobes must not repeat side effects
  property p_wr_once;
    @(posedge clock_in) disable iff (reset_in) (wr_act ##1 wr_act) |-> !wr_start;
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("write repeated");
  property p_rd_once;
    @(posedge clock_in) disable iff (reset_in) (rd_act ##1 rd_act) |-> !rd_start;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read repeated");
  property p_flag_clear;
    @(posedge clock_in) disable iff (reset_in)
      (rd_start && sel[2] && register_select_lines_in == PAR_STAT_OFS && !(printer_ack_in && !ack_q))
      |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by read");
  property p_cov_dtr_low;
    @(posedge clock_in) terminal_ready_out != 2'h3;
  endproperty
  c_dtr_low: cover property (p_cov_dtr_low);
  property p_cov_flag_mode;
    @(posedge clock_in) parallel_irq_source_sel_in && parallel_irq_out;
  endproperty
  c_flag_mode: cover property (p_cov_flag_mode);
  property p_cov_msr_read;
    @(posedge clock_in) rd_start && sel[0] && register_select_lines_in == SER_MSR_OFS;
  endproperty
  c_msr_read: cover property (p_cov_msr_read);
  property p_cov_par_irq;
    @(posedge clock_in) parallel_irq_oe_out && parallel_irq_out;
  endproperty
  c_par_irq: cover property (p_cov_par_irq);
  property p_cov_ser_irq;
    @(posedge clock_in) serial_irq_oe_out[1] && serial_irq_out[1];
  endproperty
  c_ser_irq: cover property (p_cov_ser_irq);
endmodule

// File: src/host_pin_pkg.sv
// Constants shared by the host pin logic and its serial channel registers.
// Assumes an 8-bit host bus with three register-select lines.
package host_pin_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  // Serial channel register offsets
  localparam logic [2:0] SER_DATA_OFS = 3'h0;
  localparam logic [2:0] SER_IER_OFS = 3'h1;
  localparam logic [2:0] SER_IIR_OFS = 3'h2;
  localparam logic [2:0] SER_LCR_OFS = 3'h3;
  localparam logic [2:0] SER_MCR_OFS = 3'h4;
  localparam logic [2:0] SER_LSR_OFS = 3'h5;
  localparam logic [2:0] SER_MSR_OFS = 3'h6;
  localparam logic [2:0] SER_SCR_OFS = 3'h7;
  // Parallel port register offsets
  localparam logic [2:0] PAR_DATA_OFS = 3'h0;
  localparam logic [2:0] PAR_STAT_OFS = 3'h1;
  localparam logic [2:0] PAR_CTRL_OFS = 3'h2;
  // Field positions
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_IRQ_EN_BIT = 3;
  localparam int MSR_DDSR_BIT = 1;
  localparam int MSR_DSR_BIT = 5;
  localparam int IER_RDA_BIT = 0;
  localparam int IER_THR_BIT = 1;
  localparam int IER_ERR_BIT = 2;
  localparam int IER_MS_BIT = 3;
  localparam int CTRL_INIT_BIT = 2;
  localparam int CTRL_IRQ_EN_BIT = 4;
  localparam int STAT_PRINT_BIT = 2;
  // Interrupt identification codes
  localparam logic [7:0] IIR_NONE = 8'h01;
  localparam logic [7:0] IIR_ERR = 8'h06;
  localparam logic [7:0] IIR_RDA = 8'h04;
  localparam logic [7:0] IIR_THR = 8'h02;
  localparam logic [7:0] IIR_MS = 8'h00;
  // Reset values
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h04;
  localparam logic [7:0] REG_RESET = 8'h00;
endpackage

// File: src/serial_channel_regs.sv
// One serial channel: control, status and interrupt registers.
// Assumes one-cycle read and write pulses from the host decoder.
`timescale 1ns/1ps
module serial_channel_regs
  import host_pin_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [2:0] addr_in,
  input wire logic read_pulse_in,
  input wire logic write_pulse_in,
  input wire logic [7:0] wdata_in,
  input wire logic set_ready_in,
  input wire logic rx_avail_in,
  input wire logic line_error_in,
  input wire logic tx_empty_in,
  input wire logic [7:0] rx_data_in,
  output logic [7:0] rdata_out,
  output logic terminal_ready_out,
  output logic irq_out,
  output logic irq_oe_out,
  output logic rx_read_out,
  output logic line_status_read_out,
  output logic tx_write_out
);
  logic [7:0] mcr_q, mcr_d, ier_q, ier_d, lcr_q, lcr_d, scr_q, scr_d;
  logic dsr_q, dsr_d, delta_q, delta_d, thre_q, thre_d;
  logic txe_q, txe_d, irq_q, irq_d;
  logic src_err, src_rda, src_thr, src_ms;
  logic [7:0] iir, modem_status_reg, lsr;

  always_comb begin
    src_err = ier_q[IER_ERR_BIT] & line_error_in;
    src_rda = ier_q[IER_RDA_BIT] & rx_avail_in;
    src_thr = ier_q[IER_THR_BIT] & thre_q;
    src_ms = ier_q[IER_MS_BIT] & delta_q;
    if (src_err) begin
      iir = IIR_ERR;
    end else if (src_rda) begin
      iir = IIR_RDA;
    end else if (src_thr) begin
      iir = IIR_THR;
    end else if (src_ms) begin
      iir = IIR_MS;
    end else begin
      iir = IIR_NONE;
    end
    modem_status_reg = 8'h00;
    modem_status_reg[MSR_DSR_BIT] = dsr_q;
    modem_status_reg[MSR_DDSR_BIT] = delta_q;
    lsr = {1'b0, tx_empty_in, tx_empty_in, 1'b0, line_error_in, 2'h0, rx_avail_in};
    case (addr_in)
      SER_DATA_OFS: rdata_out = rx_data_in;
      SER_IER_OFS: rdata_out = ier_q;
      SER_IIR_OFS: rdata_out = iir;
      SER_LCR_OFS: rdata_out = lcr_q;
      SER_MCR_OFS: rdata_out = mcr_q;
      SER_LSR_OFS: rdata_out = lsr;
      SER_MSR_OFS: rdata_out = modem_status_reg;
      default: rdata_out = scr_q;
    endcase
  end

  always_comb begin
    mcr_d = mcr_q;
    ier_d = ier_q;
    lcr_d = lcr_q;
    scr_d = scr_q;
    txe_d = tx_empty_in;
    dsr_d = set_ready_in;
    thre_d = thre_q;
    delta_d = delta_q;
    if (write_pulse_in) begin
      case (addr_in)
        SER_IER_OFS: ier_d = wdata_in;
        SER_LCR_OFS: lcr_d = wdata_in;
        SER_MCR_OFS: mcr_d = wdata_in;
        SER_SCR_OFS: scr_d = wdata_in;
        default: ;
      endcase
    end
    // Clear first so that a same-cycle event wins
    if (read_pulse_in && addr_in == SER_MSR_OFS) begin
      delta_d = 1'b0;
    end
    if (set_ready_in != dsr_q) begin
      delta_d = 1'b1;
    end
    if ((write_pulse_in && addr_in == SER_DATA_OFS) ||
        (read_pulse_in && addr_in == SER_IIR_OFS && iir == IIR_THR)) begin
      thre_d = 1'b0;
    end
    if ((tx_empty_in && !txe_q) || (write_pulse_in && addr_in == SER_IER_OFS)) begin
      thre_d = tx_empty_in;
    end
    irq_d = src_err | src_rda | src_thr | src_ms;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mcr_q <= MCR_RESET;
      ier_q <= REG_RESET;
      lcr_q <= REG_RESET;
      scr_q <= REG_RESET;
      dsr_q <= 1'b0;
      delta_q <= 1'b0;
      thre_q <= 1'b0;
      txe_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      mcr_q <= mcr_d;
      ier_q <= ier_d;
      lcr_q <= lcr_d;
      scr_q <= scr_d;
      dsr_q <= dsr_d;
      delta_q <= delta_d;
      thre_q <= thre_d;
      txe_q <= txe_d;
      irq_q <= irq_d;
    end
  end

  assign terminal_ready_out = ~mcr_q[MCR_DTR_BIT];
  assign irq_oe_out = mcr_q[MCR_IRQ_EN_BIT];
  assign irq_out = irq_q;
  assign rx_read_out = read_pulse_in && addr_in == SER_DATA_OFS;
  assign line_status_read_out = read_pulse_in && addr_in == SER_LSR_OFS;
  assign tx_write_out = write_pulse_in && addr_in == SER_DATA_OFS;

  property p_delta_set;
    @(posedge clock_in) disable iff (reset_in) (set_ready_in != dsr_q) |=> delta_q;
  endproperty
  a_delta_set: assert property (p_delta_set) else $error("delta not set on change");
  property p_delta_clear;
    @(posedge clock_in) disable iff (reset_in)
      (read_pulse_in && addr_in == SER_MSR_OFS && set_ready_in == dsr_q) |=> !delta_q;
  endproperty
  a_delta_clear: assert property (p_delta_clear) else $error("delta not cleared by read");
  property p_ms_irq;
    @(posedge clock_in) disable iff (reset_in) (ier_q[IER_MS_BIT] && delta_q) |=> irq_out;
  endproperty
  a_ms_irq: assert property (p_ms_irq) else $error("modem irq missing");
  property p_thr_service;
    @(posedge clock_in) disable iff (reset_in)
      (write_pulse_in && addr_in == SER_DATA_OFS && !src_err && !src_rda && !src_ms
       && !tx_empty_in && ier_q[IER_MS_BIT] == 1'b0 && ier_q[IER_ERR_BIT] == 1'b0
       && ier_q[IER_RDA_BIT] == 1'b0) |-> ##2 !irq_out;
  endproperty
  a_thr_service: assert property (p_thr_service) else $error("irq held after service");
endmodule

// File: verification/host_cpu_model.sv
// Host CPU model: drives selects, strobes, register select and write data.
// Assumes the bench clock, the design's registered read data and its combinational bus enable.
`timescale 1ns/1ps
module host_cpu_model (
  input wire logic clock_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe_out,
  output logic [2:0] register_select_lines_out,
  output logic [2:0] select_n_out,
  output logic host_read_strobe_n_out,
  output logic host_write_strobe_n_out,
  output logic [7:0] write_data_out
);
  initial begin
    register_select_lines_out = 3'h0;
    select_n_out = 3'h7;
    host_read_strobe_n_out = 1'b1;
    host_write_strobe_n_out = 1'b1;
    write_data_out = 8'h00;
  end

  // Released lines show the inverse, so stale values never look valid
  task automatic release_bus(input logic [2:0] addr, input logic [7:0] data);
    select_n_out <= 3'h7;
    host_read_strobe_n_out <= 1'b1;
    host_write_strobe_n_out <= 1'b1;
    register_select_lines_out <= ~addr;
    write_data_out <= ~data;
  endtask

  task automatic wr(input int unsigned port, input logic [2:0] addr, input logic [7:0] data);
    @(posedge clock_in);
    select_n_out <= ~(3'h1 << port);
    register_select_lines_out <= addr;
    write_data_out <= data;
    host_write_strobe_n_out <= 1'b0;
    @(posedge clock_in);
    release_bus(addr, data);
  endtask

  // Data is registered, so it is taken just after the capturing edge
  task automatic rd(input int unsigned port, input logic [2:0] addr, output logic [7:0] data,
                    output logic oe);
    @(posedge clock_in);
    select_n_out <= ~(3'h1 << port);
    register_select_lines_out <= addr;
    host_read_strobe_n_out <= 1'b0;
    @(posedge clock_in);
    #1;
    data = host_data_bus_out;
    oe = host_data_bus_oe_out;
    @(posedge clock_in);
    release_bus(addr, data);
  endtask
endmodule

// File: verification/test_host_pin_logic.sv
// Self-checking bench for the host pin logic, one task per scenario.
// Assumes the host CPU model and a 40 MHz clock; printer init wire has a pull-up.
`timescale 1ns/1ps
module test_host_pin_logic
  import host_pin_pkg::*;
;
  logic clock_in, reset_in, ack, src_sel, busy, pe, slct, err_n, oe;
  logic [1:0] set_ready, rx_avail, line_error, tx_empty, term_rdy, irq, irq_oe;
  logic [1:0] rx_read, lsr_read, tx_write;
  logic [15:0] rx_data;
  logic [7:0] rdata, wdata, d;
  logic [2:0] addr, sel_n;
  logic rd_n, wr_n, bus_oe, par_irq, par_oe, init_out, init_oe;
  wire logic init_wire;
  int errors = 0;
  int checked = 0;
  int n_rx = 0;
  int n_lsr = 0;
  int n_tx = 0;

  // Counts the one-cycle datapath pulses
  always @(posedge clock_in) begin
    n_rx += $countones(rx_read);
    n_lsr += $countones(lsr_read);
    n_tx += $countones(tx_write);
  end

  assign init_wire = init_oe ? init_out : 1'b1;

  host_cpu_model u_host (.clock_in(clock_in), .host_data_bus_out(rdata), .host_data_bus_oe_out(bus_oe),
    .register_select_lines_out(addr), .select_n_out(sel_n), .host_read_strobe_n_out(rd_n),
    .host_write_strobe_n_out(wr_n), .write_data_out(wdata));

  host_pin_logic u_dut (.clock_in(clock_in), .reset_in(reset_in), .register_select_lines_in(addr),
    .select_serial_a_n_in(sel_n[0]), .select_serial_b_n_in(sel_n[1]), .select_lineport_n_in(sel_n[2]),
    .host_read_strobe_n_in(rd_n), .host_write_strobe_n_in(wr_n), .host_data_bus_in(wdata),
    .host_data_bus_out(rdata), .host_data_bus_oe_out(bus_oe), .set_ready_in(set_ready),
    .terminal_ready_out(term_rdy), .rx_avail_in(rx_avail), .line_error_in(line_error),
    .tx_empty_in(tx_empty), .rx_data_in(rx_data), .rx_read_out(rx_read), .line_status_read_out(lsr_read),
    .tx_write_out(tx_write), .serial_irq_out(irq), .serial_irq_oe_out(irq_oe), .printer_ack_in(ack),
    .printer_busy_in(busy), .paper_empty_in(pe), .printer_select_in(slct), .printer_error_n_in(err_n),
    .parallel_irq_source_sel_in(src_sel), .parallel_irq_out(par_irq), .parallel_irq_oe_out(par_oe),
    .printer_init_in(init_wire), .printer_init_out(init_out), .printer_init_oe_out(init_oe));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic end_sim();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic t_reset();
    check(8'({term_rdy, irq_oe, par_oe, init_oe, bus_oe}), 8'h60, "reset pins");
  endtask

  task automatic t_dtr();
    u_host.wr(0, SER_MCR_OFS, 8'h09);
    tick(1);
    check(8'(term_rdy), 8'h02, "ready a set");
    check(8'(irq_oe), 8'h01, "irq enable a");
    u_host.wr(1, SER_MCR_OFS, 8'h09);
    u_host.wr(0, SER_MCR_OFS, 8'h00);
    tick(1);
    check(8'(term_rdy), 8'h01, "ready b only");
    check(8'(irq_oe), 8'h02, "irq enable b");
    // Reset in mid-run while channel b is programmed
    @(posedge clock_in);
    reset_in <= 1'b1;
    tick(2);
    check(8'({term_rdy, irq_oe}), 8'h0c, "mid reset");
    @(posedge clock_in);
    reset_in <= 1'b0;
    tick(1);
  endtask

  task automatic t_regs();
    u_host.wr(1, SER_SCR_OFS, 8'ha5);
    u_host.wr(0, SER_SCR_OFS, 8'h3c);
    u_host.rd(1, SER_SCR_OFS, d, oe);
    check(d, 8'ha5, "scratch b");
    check(8'(oe), 8'h01, "bus driven");
    u_host.rd(0, SER_SCR_OFS, d, oe);
    check(d, 8'h3c, "scratch a");
    tick(1);
    check(8'(bus_oe), 8'h00, "bus floats");
  endtask

  task automatic t_dsr();
    @(posedge clock_in);
    set_ready <= 2'b01;
    tick(2);
    u_host.rd(0, SER_MSR_OFS, d, oe);
    check(d, 8'h22, "status level and change");
    u_host.rd(0, SER_MSR_OFS, d, oe);
    check(d, 8'h20, "change cleared");
    u_host.rd(1, SER_MSR_OFS, d, oe);
    check(d, 8'h00, "other channel quiet");
  endtask

  task automatic t_serial_irq();
    u_host.wr(0, SER_MCR_OFS, 8'h08);
    u_host.wr(0, SER_IER_OFS, 8'h09);
    tick(2);
    check(8'(irq), 8'h00, "no source");
    @(posedge clock_in);
    set_ready <= 2'b00;
    tick(3);
    check(8'(irq), 8'h01, "modem irq");
    u_host.rd(0, SER_MSR_OFS, d, oe);
    check(d, 8'h02, "low level changed");
    tick(3);
    check(8'(irq), 8'h00, "modem serviced");
    @(posedge clock_in);
    rx_avail <= 2'b01;
    tick(3);
    check(8'(irq), 8'h01, "rx irq");
    u_host.rd(0, SER_IIR_OFS, d, oe);
    check(d, IIR_RDA, "rx source code");
    u_host.rd(0, SER_DATA_OFS, d, oe);
    check(d, 8'hc3, "rx byte");
    // Receive path empties once its byte was taken
    @(posedge clock_in);
    rx_avail <= 2'b00;
    tick(3);
    check(8'(irq), 8'h00, "rx serviced");
  endtask

  task automatic t_pulses();
    u_host.rd(0, SER_LSR_OFS, d, oe);
    check(d, 8'h00, "line status idle");
    u_host.wr(2, PAR_DATA_OFS, 8'h5a);
    u_host.rd(2, PAR_DATA_OFS, d, oe);
    check(d, 8'h5a, "printer data");
    u_host.wr(0, SER_IER_OFS, 8'h02);
    @(posedge clock_in);
    tx_empty <= 2'b01;
    tick(3);
    check(8'(irq), 8'h01, "tx irq");
    u_host.rd(0, SER_IIR_OFS, d, oe);
    check(d, IIR_THR, "tx source code");
    tick(3);
    check(8'(irq), 8'h00, "tx served by id read");
    @(posedge clock_in);
    tx_empty <= 2'b00;
    tick(1);
    @(posedge clock_in);
    tx_empty <= 2'b01;
    tick(3);
    check(8'(irq), 8'h01, "tx irq again");
    @(posedge clock_in);
    tx_empty <= 2'b00;
    tick(1);
    u_host.wr(0, SER_DATA_OFS, 8'h55);
    tick(2);
    check(8'(irq), 8'h00, "tx served by write");
    check(8'(n_rx), 8'h01, "data read pulses");
    check(8'(n_lsr), 8'h01, "status read pulses");
    check(8'(n_tx), 8'h01, "data write pulses");
  endtask

  task automatic t_par_irq();
    u_host.wr(2, PAR_CTRL_OFS, 8'h14);
    tick(1);
    check(8'({par_oe, init_oe}), 8'h02, "par irq enabled");
    @(posedge clock_in);
    ack <= 1'b1;
    tick(3);
    check(8'(par_irq), 8'h01, "ack mode rise");
    @(posedge clock_in);
    ack <= 1'b0;
    tick(3);
    check(8'(par_irq), 8'h00, "ack mode follows");
    u_host.rd(2, PAR_STAT_OFS, d, oe);
    @(posedge clock_in);
    src_sel <= 1'b1;
    tick(3);
    check(8'(par_irq), 8'h00, "flag mode idle");
    @(posedge clock_in);
    ack <= 1'b1;
    tick(3);
    check(8'(par_irq), 8'h01, "flag mode rise");
    @(posedge clock_in);
    ack <= 1'b0;
    tick(3);
    check(8'(par_irq), 8'h01, "flag held");
    u_host.rd(2, PAR_STAT_OFS, d, oe);
    check(d, 8'h9c, "status with flag");
    tick(3);
    check(8'(par_irq), 8'h00, "flag cleared");
    u_host.wr(2, PAR_CTRL_OFS, 8'h10);
    tick(1);
    check(8'({par_oe, init_oe, init_wire}), 8'h06, "init pulled");
    u_host.wr(2, PAR_CTRL_OFS, 8'h04);
    tick(1);
    check(8'({par_oe, init_oe, init_wire}), 8'h01, "par irq floats");
  endtask

  initial begin
    repeat (20000) @(posedge clock_in);
    errors++;
    $display("mismatch at %0t: run limit reached", $time);
    end_sim();
  end

  initial begin
    reset_in = 1'b1;
    set_ready = 2'b00;
    rx_avail = 2'b00;
    line_error = 2'b00;
    tx_empty = 2'b00;
    rx_data = 16'h5ac3;
    ack = 1'b0;
    src_sel = 1'b0;
    busy = 1'b0;
    pe = 1'b0;
    slct = 1'b1;
    err_n = 1'b1;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    tick(1);
    t_reset();
    t_dtr();
    t_regs();
    t_dsr();
    t_serial_irq();
    t_pulses();
    t_par_irq();
    end_sim();
  end
endmodule
